// ### design/flash_ctrl_pkg.sv
// Package: register map, field positions, types and constants of the flash controller
//
// Notes on behaviour
// - program stores AND of new and old
// - program errors reported as failure
// - per 2 kB block protection, readable back
// - full access allows read, fetch, erase, program
// - no-modify refuses erase and program
// - fetch-only refuses data and debug reads
// - protection changes may only tighten
// - loosening refused by hardware with failure
// - uncommitted protection reverts at reset
// - violations flagged through the flash interrupt
// - protection commit permanent, failure reported
// - clocks per microsecond time the pulses
// - two user words settable, readable, errors
// - user commit stores words permanently
// - erase 1 kB block to all ones
// - completion interrupt separate, individually clearable
// - raw and masked status, per-source enable
package flash_ctrl_pkg;

  localparam int DATA_W = 32;
  localparam int REG_AW = 8;
  localparam int USEC_W = 8;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [REG_AW-1:0] OFS_ADDR = 8'h00;
  localparam logic [REG_AW-1:0] OFS_WDATA = 8'h04;
  localparam logic [REG_AW-1:0] OFS_CMD = 8'h08;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h0C;
  localparam logic [REG_AW-1:0] OFS_USEC = 8'h10;
  localparam logic [REG_AW-1:0] OFS_PROT = 8'h14;
  localparam logic [REG_AW-1:0] OFS_USER0 = 8'h18;
  localparam logic [REG_AW-1:0] OFS_USER1 = 8'h1C;
  localparam logic [REG_AW-1:0] OFS_RIS = 8'h20;
  localparam logic [REG_AW-1:0] OFS_IM = 8'h24;
  localparam logic [REG_AW-1:0] OFS_MIS = 8'h28;

  // ****************************************
  // Field positions and geometry
  // ****************************************
  localparam int CMD_LSB = 0;
  localparam int CMD_PROT_LSB = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FAIL = 1;
  localparam int STAT_USER_LOCK = 2;
  localparam int IRQ_OP_DONE = 0;
  localparam int IRQ_BAD_ACCESS = 1;
  localparam int WORD_SHIFT = 2;
  localparam int ERASE_SHIFT = 10;
  localparam int PROT_SHIFT = 11;
  localparam int ERASE_BYTES = 1024;
  localparam int WORDS_PER_ERASE = ERASE_BYTES / 4;

  // ****************************************
  // Reset values, erased word and bus response codes
  // ****************************************
  localparam logic [USEC_W-1:0] USEC_RST = 8'h00;
  localparam logic [1:0] IM_RST = 2'h0;
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    prot_full_access = 2'h0,
    prot_no_modify = 2'h1,
    prot_fetch_only = 2'h2
  } prot_t;

  typedef enum logic [2:0] {
    cmd_none, cmd_program, cmd_erase, cmd_prot_set, cmd_prot_commit, cmd_user_commit
  } cmd_t;

  typedef enum logic [1:0] {acc_fetch, acc_data, acc_debug} acc_t;

  typedef struct packed {
    logic valid;
    acc_t kind;
    logic [DATA_W-1:0] addr;
  } rd_req_t;

  typedef struct packed {
    logic valid;
    logic denied;
    logic [DATA_W-1:0] data;
  } rd_rsp_t;

endpackage

// ### design/usec_tick.sv
// Microsecond tick divider driven by the programmed clocks-per-microsecond count
`timescale 1ns/1ps
module usec_tick
  import flash_ctrl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic [USEC_W-1:0] i_clocks_per_usec,
  output logic o_tick
);

  logic [USEC_W-1:0] cnt_ff;

  // Restarts with every operation so the first microsecond is whole
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cnt_ff <= '0;
    end else if (!i_run || o_tick) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign o_tick = i_run && (i_clocks_per_usec != '0) && (cnt_ff == i_clocks_per_usec - 8'h01);

endmodule

// ### design/flash_program_protect_ctrl.sv
// Flash controller: word programming, erase, block protection, user words, AXI4-Lite registers
`timescale 1ns/1ps
module flash_program_protect_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int ERASE_BLOCKS = 8,
  parameter logic [USEC_W-1:0] PROG_US = 8'h14,
  parameter logic [USEC_W-1:0] ERASE_US = 8'h20,
  parameter logic [USEC_W-1:0] COMMIT_US = 8'h10
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_power_on,
  input wire rd_req_t i_rd_req,
  output rd_rsp_t o_rd_rsp,
  output logic o_busy,
  output logic o_irq,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [REG_AW-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [REG_AW-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp
);

  localparam int EB_W = $clog2(ERASE_BLOCKS);
  localparam int AW = EB_W + ERASE_SHIFT - WORD_SHIFT;
  localparam int WORDS = ERASE_BLOCKS * WORDS_PER_ERASE;
  localparam int PROT_BLOCKS = ERASE_BLOCKS / 2;

  if (ERASE_BLOCKS < 4 || (ERASE_BLOCKS & (ERASE_BLOCKS - 1)) != 0) begin : g_chk
    $error("ERASE_BLOCKS must be a power of two, at least 4");
  end

  // ****************************************
  // Address helpers
  // ****************************************
  function automatic logic in_range(input logic [DATA_W-1:0] a);
    return a[DATA_W-1:AW+WORD_SHIFT] == '0;
  endfunction

  function automatic logic [AW-1:0] word_of(input logic [DATA_W-1:0] a);
    return a[AW+WORD_SHIFT-1:WORD_SHIFT];
  endfunction

  function automatic logic [EB_W-2:0] pblk_of(input logic [DATA_W-1:0] a);
    return a[AW+WORD_SHIFT-1:PROT_SHIFT];
  endfunction

  function automatic logic tightens(input logic [1:0] old, input logic [1:0] nw);
    return (nw <= prot_fetch_only) && (nw >= old);
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] nw,
                                              input logic [3:0] strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [REG_AW-1:0] a);
    return a <= OFS_MIS && a[1:0] == 2'h0;
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {st_load, st_idle, st_pulse, st_finish} st_t;

  st_t state_ff;
  cmd_t op_ff;
  logic op_fail_ff;
  logic [USEC_W-1:0] cnt_ff;
  logic [DATA_W-1:0] op_addr_ff;
  logic [DATA_W-1:0] op_data_ff;
  logic fail_ff;
  logic [DATA_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [USEC_W-1:0] usec_ff;
  logic [DATA_W-1:0] user_ff [2];
  logic [DATA_W-1:0] user_nv_ff [2];
  logic user_lock_ff;
  prot_t prot_ff [PROT_BLOCKS];
  prot_t prot_nv_ff [PROT_BLOCKS];
  logic [DATA_W-1:0] mem_ff [WORDS];
  logic [1:0] ris_ff;
  logic [1:0] im_ff;
  logic aw_hold_ff;
  logic [REG_AW-1:0] aw_addr_ff;
  logic w_hold_ff;
  logic [DATA_W-1:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  rd_rsp_t rsp_ff;

  logic wr_go;
  logic [DATA_W-1:0] wr_val;
  logic start;
  cmd_t cmd_code;
  logic [1:0] new_prot;
  prot_t cur_prot;
  logic start_bad;
  logic start_viol;
  logic [USEC_W-1:0] start_us;
  logic do_op;
  logic tick;
  logic deny_now;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [DATA_W-1:0] rd_mux;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign o_awready = !aw_hold_ff && !bvalid_ff;
  assign o_wready = !w_hold_ff && !bvalid_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign wr_go = aw_hold_ff && w_hold_ff;
  assign wr_val = merge('0, w_data_ff, w_strb_ff);

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_hold_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= i_wdata;
        w_strb_ff <= i_wstrb;
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= is_mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && i_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Software-written settings
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      addr_ff <= '0;
      wdata_ff <= '0;
      usec_ff <= USEC_RST;
      im_ff <= IM_RST;
    end else if (wr_go) begin
      if (aw_addr_ff == OFS_ADDR) begin
        addr_ff <= merge(addr_ff, w_data_ff, w_strb_ff);
      end
      if (aw_addr_ff == OFS_WDATA) begin
        wdata_ff <= merge(wdata_ff, w_data_ff, w_strb_ff);
      end
      if (aw_addr_ff == OFS_USEC) begin
        usec_ff <= wr_val[USEC_W-1:0];
      end
      if (aw_addr_ff == OFS_IM) begin
        im_ff <= wr_val[1:0];
      end
    end
  end

  // ****************************************
  // Command decode and checks
  // ****************************************
  assign cmd_code = cmd_t'(w_data_ff[CMD_LSB +: 3]);
  assign new_prot = w_data_ff[CMD_PROT_LSB +: 2];
  assign cur_prot = prot_ff[pblk_of(addr_ff)];
  assign start = wr_go && aw_addr_ff == OFS_CMD && w_strb_ff[0] && state_ff == st_idle;

  always_comb begin
    start_bad = 1'b1;
    start_viol = 1'b0;
    start_us = '0;
    case (cmd_code)
      cmd_program: begin
        start_viol = cur_prot != prot_full_access;
        start_bad = !in_range(addr_ff) || addr_ff[1:0] != 2'h0 || usec_ff == '0 ||
                    start_viol;
        start_us = PROG_US;
      end
      cmd_erase: begin
        start_viol = cur_prot != prot_full_access;
        start_bad = !in_range(addr_ff) || addr_ff[ERASE_SHIFT-1:0] != '0 || usec_ff == '0 ||
                    start_viol;
        start_us = ERASE_US;
      end
      cmd_prot_set: begin
        start_bad = !in_range(addr_ff) || !tightens(cur_prot, new_prot);
      end
      cmd_prot_commit: begin
        start_bad = usec_ff == '0;
        start_us = COMMIT_US;
      end
      cmd_user_commit: begin
        start_bad = usec_ff == '0 || user_lock_ff;
        start_us = COMMIT_US;
      end
      default: begin
        start_bad = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Operation sequencer
  // ****************************************
  usec_tick u_tick (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_run(state_ff == st_pulse),
    .i_clocks_per_usec(usec_ff),
    .o_tick(tick)
  );

  assign do_op = state_ff == st_pulse && cnt_ff == '0;
  assign o_busy = state_ff != st_idle;

  // Register file copies are not frozen during an operation, so targets are latched at start
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= st_load;
      op_ff <= cmd_none;
      op_fail_ff <= 1'b0;
      cnt_ff <= '0;
      op_addr_ff <= '0;
      op_data_ff <= '0;
      fail_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        st_load: begin
          state_ff <= st_idle;
        end
        st_idle: begin
          if (start) begin
            op_ff <= cmd_code;
            op_fail_ff <= start_bad;
            cnt_ff <= start_us;
            op_addr_ff <= addr_ff;
            op_data_ff <= wdata_ff;
            state_ff <= (start_bad || cmd_code == cmd_prot_set) ? st_finish : st_pulse;
          end
        end
        st_pulse: begin
          if (do_op) begin
            state_ff <= st_finish;
          end else if (tick) begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        st_finish: begin
          fail_ff <= op_fail_ff;
          state_ff <= st_idle;
        end
      endcase
      if (wr_go && user_lock_ff && (aw_addr_ff == OFS_USER0 || aw_addr_ff == OFS_USER1)) begin
        fail_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // Flash array, survives system reset
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_power_on) begin
    if (i_power_on) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_ff[i] <= ERASED_WORD;
      end
    end else if (do_op && op_ff == cmd_program) begin
      mem_ff[word_of(op_addr_ff)] <= mem_ff[word_of(op_addr_ff)] & op_data_ff;
    end else if (do_op && op_ff == cmd_erase) begin
      for (int i = 0; i < WORDS; i++) begin
        if (i / WORDS_PER_ERASE == int'(op_addr_ff[AW+WORD_SHIFT-1:ERASE_SHIFT])) begin
          mem_ff[i] <= ERASED_WORD;
        end
      end
    end
  end

  // ****************************************
  // Protection and user words
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      for (int b = 0; b < PROT_BLOCKS; b++) begin
        prot_ff[b] <= prot_full_access;
      end
    end else if (state_ff == st_load) begin
      prot_ff <= prot_nv_ff;
    end else if (start && cmd_code == cmd_prot_set && !start_bad) begin
      prot_ff[pblk_of(addr_ff)] <= prot_t'(new_prot);
    end
  end

  // Committed copies model the nonvolatile cells: only power-on clears them
  always_ff @(posedge i_mclk or posedge i_power_on) begin
    if (i_power_on) begin
      for (int b = 0; b < PROT_BLOCKS; b++) begin
        prot_nv_ff[b] <= prot_full_access;
      end
      user_nv_ff[0] <= ERASED_WORD;
      user_nv_ff[1] <= ERASED_WORD;
      user_lock_ff <= 1'b0;
    end else if (do_op && op_ff == cmd_prot_commit) begin
      prot_nv_ff <= prot_ff;
    end else if (do_op && op_ff == cmd_user_commit) begin
      user_nv_ff <= user_ff;
      user_lock_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      user_ff[0] <= ERASED_WORD;
      user_ff[1] <= ERASED_WORD;
    end else if (state_ff == st_load) begin
      user_ff <= user_nv_ff;
    end else if (wr_go && !user_lock_ff) begin
      if (aw_addr_ff == OFS_USER0) begin
        user_ff[0] <= merge(user_ff[0], w_data_ff, w_strb_ff);
      end
      if (aw_addr_ff == OFS_USER1) begin
        user_ff[1] <= merge(user_ff[1], w_data_ff, w_strb_ff);
      end
    end
  end

  // ****************************************
  // Processor and debugger read port
  // ****************************************
  assign deny_now = i_rd_req.valid && (!in_range(i_rd_req.addr) ||
                    (i_rd_req.kind != acc_fetch &&
                     prot_ff[pblk_of(i_rd_req.addr)] == prot_fetch_only));
  assign o_rd_rsp = rsp_ff;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= i_rd_req.valid;
      rsp_ff.denied <= deny_now;
      rsp_ff.data <= (i_rd_req.valid && !deny_now) ? mem_ff[word_of(i_rd_req.addr)] : '0;
    end
  end

  // ****************************************
  // Interrupt sources
  // ****************************************
  assign irq_set[IRQ_OP_DONE] = state_ff == st_finish &&
                                (op_ff == cmd_program || op_ff == cmd_erase);
  assign irq_set[IRQ_BAD_ACCESS] = deny_now || (start && start_viol);
  assign irq_clr = (wr_go && aw_addr_ff == OFS_RIS) ? wr_val[1:0] : 2'h0;
  assign o_irq = |(ris_ff & im_ff);

  // A new event beats a clear written in the same cycle
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ris_ff <= 2'h0;
    end else begin
      ris_ff <= (ris_ff & ~irq_clr) | irq_set;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign o_arready = !rvalid_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;

  always_comb begin
    rd_mux = '0;
    case (i_araddr)
      OFS_ADDR: rd_mux = addr_ff;
      OFS_WDATA: rd_mux = wdata_ff;
      OFS_STATUS: rd_mux = {29'h0, user_lock_ff, fail_ff, o_busy};
      OFS_USEC: rd_mux = {24'h0, usec_ff};
      OFS_PROT: rd_mux = {30'h0, cur_prot};
      OFS_USER0: rd_mux = user_ff[0];
      OFS_USER1: rd_mux = user_ff[1];
      OFS_RIS: rd_mux = {30'h0, ris_ff};
      OFS_IM: rd_mux = {30'h0, im_ff};
      OFS_MIS: rd_mux = {30'h0, ris_ff & im_ff};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= is_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence bad_start_s;
    start && start_bad;
  endsequence

  sequence fail_shown_s;
    state_ff == st_finish ##1 (fail_ff && !o_busy);
  endsequence

  busy_from_start_a: assert property (start |=> o_busy)
    else $error("busy not raised after command accepted");
  program_and_a: assert property (do_op && op_ff == cmd_program && !i_power_on |=>
      mem_ff[$past(word_of(op_addr_ff))] ==
      ($past(mem_ff[word_of(op_addr_ff)]) & $past(op_data_ff)))
    else $error("programmed word is not the AND of old and new");
  erase_ones_a: assert property (do_op && op_ff == cmd_erase |=>
      mem_ff[{$past(op_addr_ff[AW+WORD_SHIFT-1:ERASE_SHIFT]), 8'h00}] == ERASED_WORD)
    else $error("erased block not all ones");
  // The target block was latched into op_addr_ff at the refused start
  loosen_refused_a: assert property (bad_start_s ##0 (cmd_code == cmd_prot_set)
      |=> prot_ff[pblk_of(op_addr_ff)] == $past(cur_prot) ##0 fail_shown_s)
    else $error("loosening protection not refused");
  no_modify_a: assert property (start && cmd_code == cmd_program && cur_prot == prot_no_modify
      |=> fail_shown_s)
    else $error("program to no-modify block not failed");
  fetch_deny_a: assert property (i_rd_req.valid && i_rd_req.kind != acc_fetch
      && in_range(i_rd_req.addr) && prot_ff[pblk_of(i_rd_req.addr)] == prot_fetch_only
      |=> rsp_ff.denied && rsp_ff.data == '0 ##0 ris_ff[IRQ_BAD_ACCESS])
    else $error("data read of fetch-only block not denied");
  // A mask write landing in the same cycle may legally hide the source
  bad_irq_a: assert property (deny_now && im_ff[IRQ_BAD_ACCESS] && !irq_clr[IRQ_BAD_ACCESS]
      && !(wr_go && aw_addr_ff == OFS_IM) |=> o_irq)
    else $error("enabled violation did not raise the interrupt");
  done_irq_a: assert property (state_ff == st_finish && op_ff == cmd_erase
      |=> ris_ff[IRQ_OP_DONE] && !o_busy)
    else $error("completion source not set after erase");

endmodule

// ### tb/flash_core_model.sv
// Model of the processor core and debugger issuing flash reads
`timescale 1ns/1ps
module flash_core_model
  import flash_ctrl_pkg::*;
(
  input wire logic i_mclk,
  output rd_req_t o_rd_req,
  input wire rd_rsp_t i_rd_rsp
);
  initial o_rd_req = '0;
  // One read per call; the answer is registered, so it is taken a cycle on
  task automatic rd(input acc_t k, input logic [DATA_W-1:0] a, output rd_rsp_t r);
    @(posedge i_mclk);
    o_rd_req <= '{valid: 1'b1, kind: k, addr: a};
    @(posedge i_mclk);
    // Idle address is moved away so a stale value never looks valid
    o_rd_req <= '{valid: 1'b0, kind: k, addr: ~a};
    @(negedge i_mclk);
    r = i_rd_rsp;
  endtask
endmodule

// ### tb/tb.sv
// Register-level scenarios for the flash controller
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb
  import flash_ctrl_pkg::*;
;
  logic i_mclk = 0, i_reset = 1, i_power_on = 1;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [REG_AW-1:0] i_awaddr = '0, i_araddr = '0;
  logic [DATA_W-1:0] i_wdata = '0, o_rdata, rv;
  logic [3:0] i_wstrb = 4'hF;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_busy, o_irq, bz;
  logic [1:0] o_bresp, o_rresp, rr;
  rd_req_t i_rd_req;
  rd_rsp_t o_rd_rsp, rs;
  int fail_count = 0, comparisons = 0;
  always #2 i_mclk = ~i_mclk;
  // Short pulse counts keep the run brief; expectations do not depend on them
  flash_program_protect_ctrl #(.ERASE_BLOCKS(4), .PROG_US(8'h01), .ERASE_US(8'h01),
    .COMMIT_US(8'h01)) i_dut (.i_mclk, .i_reset, .i_power_on, .i_rd_req, .o_rd_rsp,
    .o_busy, .o_irq, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready,
    .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
    .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp);
  flash_core_model i_core (.i_mclk, .o_rd_req(i_rd_req), .i_rd_rsp(o_rd_rsp));
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic summarize();
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang();
    fail_count++;
    summarize();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, b;
    b = 0;
    @(posedge i_mclk);
    i_awvalid <= 1;
    i_awaddr <= a;
    i_wvalid <= 1;
    i_wdata <= d;
    i_bready <= 1;
    for (int n = 0; n < 64 && !b; n++) begin
      @(negedge i_mclk);
      ta = o_awready;
      tw = o_wready;
      b = o_bvalid;
      rr = o_bresp;
      @(posedge i_mclk);
      if (ta) i_awvalid <= 0;
      if (tw) i_wvalid <= 0;
      if (b) i_bready <= 0;
    end
    if (!b) hang();
  endtask
  task automatic rd(input logic [7:0] a);
    logic t, v;
    v = 0;
    @(posedge i_mclk);
    i_arvalid <= 1;
    i_araddr <= a;
    i_rready <= 1;
    for (int n = 0; n < 64 && !v; n++) begin
      @(negedge i_mclk);
      t = o_arready;
      v = o_rvalid;
      rv = o_rdata;
      rr = o_rresp;
      @(posedge i_mclk);
      if (t) i_arvalid <= 0;
      if (v) i_rready <= 0;
    end
    if (!v) hang();
  endtask
  // Leaves the final status word in rv
  task automatic cmd(input logic [31:0] a, input logic [7:0] c);
    wr(OFS_ADDR, a);
    wr(OFS_CMD, {24'h0, c});
    @(negedge i_mclk);
    bz = o_busy;
    rv = 32'h1;
    for (int n = 0; n < 200 && rv[STAT_BUSY] !== 1'b0; n++) rd(OFS_STATUS);
    if (rv[STAT_BUSY] !== 1'b0) hang();
  endtask
  // Called just after a rising edge, so reset spans exactly two edges
  task automatic rst(input logic p);
    i_reset <= 1;
    i_power_on <= p;
    repeat (2) @(posedge i_mclk);
    i_reset <= 0;
    i_power_on <= 0;
    repeat (3) @(posedge i_mclk);
  endtask
  initial begin
    rst(1);
    rd(OFS_USEC);
    `CHK(rv[7:0], USEC_RST)
    rd(8'h2C);
    `CHK(rr, RESP_SLVERR)
    wr(8'h2C, 32'h0);
    `CHK(rr, RESP_SLVERR)
    wr(OFS_USEC, 32'h2);
    `CHK(rr, RESP_OKAY)
    rd(OFS_USEC);
    `CHK(rv, 32'h2)
    wr(OFS_IM, 32'h1);
    wr(OFS_WDATA, 32'hA5A5A5A5);
    cmd(32'h4, 8'h01);
    `CHK(bz, 1'b1)
    `CHK(rv[STAT_FAIL], 1'b0)
    wr(OFS_WDATA, 32'h0F0F0F0F);
    cmd(32'h4, 8'h01);
    i_core.rd(acc_data, 32'h4, rs);
    `CHK(rs.valid, 1'b1)
    `CHK(rs.data, 32'h05050505)
    `CHK(o_irq, 1'b1)
    rd(OFS_MIS);
    `CHK(rv[1:0], 2'h1)
    wr(OFS_IM, 32'h0);
    @(negedge i_mclk);
    `CHK(o_irq, 1'b0)
    rd(OFS_RIS);
    `CHK(rv[1:0], 2'h1)
    cmd(32'h6, 8'h01);
    `CHK(rv[STAT_FAIL], 1'b1)
    cmd(32'h0, 8'h02);
    i_core.rd(acc_data, 32'h4, rs);
    `CHK(rs.data, ERASED_WORD)
    wr(OFS_RIS, 32'h3);
    rd(OFS_RIS);
    `CHK(rv[1:0], 2'h0)
    wr(OFS_IM, 32'h2);
    cmd(32'h800, 8'h13);
    rd(OFS_PROT);
    `CHK(rv[1:0], prot_no_modify)
    cmd(32'h0, 8'h07);
    `CHK(rv[STAT_FAIL], 1'b1)
    cmd(32'h800, 8'h01);
    `CHK(rv[STAT_FAIL], 1'b1)
    `CHK(o_irq, 1'b1)
    cmd(32'h800, 8'h03);
    `CHK(rv[STAT_FAIL], 1'b1)
    i_core.rd(acc_data, 32'h800, rs);
    `CHK(rs.denied, 1'b0)
    cmd(32'h800, 8'h23);
    `CHK(rv[STAT_FAIL], 1'b0)
    cmd(32'h800, 8'h13);
    `CHK(rv[STAT_FAIL], 1'b1)
    for (int k = 0; k < 3; k++) begin
      i_core.rd(acc_t'(k), 32'h800, rs);
      `CHK(rs.denied, k != 0)
    end
    cmd(32'h800, 8'h02);
    `CHK(rv[STAT_FAIL], 1'b1)
    rst(0);
    cmd(32'h800, 8'h01);
    `CHK(rv[STAT_FAIL], 1'b1)
    rd(OFS_PROT);
    `CHK(rv[1:0], prot_full_access)
    wr(OFS_USEC, 32'h2);
    cmd(32'h800, 8'h13);
    cmd(32'h0, 8'h04);
    `CHK(rv[STAT_FAIL], 1'b0)
    wr(OFS_USER0, 32'h12345678);
    wr(OFS_USER1, 32'h9ABCDEF0);
    rd(OFS_USER1);
    `CHK(rv, 32'h9ABCDEF0)
    cmd(32'h0, 8'h05);
    `CHK(rv[STAT_USER_LOCK], 1'b1)
    rst(0);
    wr(OFS_ADDR, 32'h800);
    rd(OFS_PROT);
    `CHK(rv[1:0], prot_no_modify)
    wr(OFS_USER0, 32'h0);
    rd(OFS_USER0);
    `CHK(rv, 32'h12345678)
    rd(OFS_STATUS);
    `CHK(rv[STAT_FAIL], 1'b1)
    summarize();
  end
endmodule
